/* common/mmbi_pkg.sv */
// Constants and types shared by the minimum-mode bus interface
package mmbi_pkg;
  localparam int QUEUE_BYTES = 6; // Queue capacity in bytes
  localparam int FETCH_FREE = 2; // Free slots needed to fetch
  localparam int FIFO_DEPTH = 16; // Storage depth of the buffer
  localparam int FIFO_WIDTH = 8; // One instruction byte
  localparam logic [1:0] QS_NOP = 2'h0; // Nothing happened
  localparam logic [1:0] QS_FIRST = 2'h1; // First opcode byte
  localparam logic [1:0] QS_EMPTY = 2'h2; // Queue flushed
  localparam logic [1:0] QS_NEXT = 2'h3; // Subsequent byte
  localparam logic [15:0] RST_IP = 16'h0000; // Fetch pointer at reset
  localparam logic [2:0] SYNC_RST = 3'h0; // Synchroniser reset

  // Bus states, one-hot
  typedef enum logic [6:0]
  {
    MMBI_TI = 7'h01,
    MMBI_T1 = 7'h02,
    MMBI_T2 = 7'h04,
    MMBI_T3 = 7'h08,
    MMBI_TW = 7'h10,
    MMBI_T4 = 7'h20,
    MMBI_HOLD = 7'h40
  } mmbi_state_t;

  // Segment base times sixteen plus offset, 20 bits
  function automatic logic [19:0] mmbi_reloc(input logic [15:0] seg,
                                             input logic [15:0] off);
    mmbi_reloc = {seg, 4'h0} + {4'h0, off};
  endfunction
endpackage

/* common/mmbi_q_if.sv */
// Push and pop channels between the bus logic and its byte buffer
`timescale 1ns/1ps
interface mmbi_q_if #(parameter int W = 8, parameter int D = 16);
  logic push_valid; // Byte offered
  logic push_ready; // Room for it
  logic [W-1:0] push_data;
  logic pop_valid; // Head byte present
  logic pop_ready; // Consumer takes it
  logic [W-1:0] pop_data;
  logic flush; // Discard everything
  logic [$clog2(D+1)-1:0] count; // Bytes stored
  modport fifo (input push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data, count);
  modport user (output push_valid, push_data, pop_ready, flush,
                input push_ready, pop_valid, pop_data, count);
endinterface

/* core/mmbi_fifo.sv */
// Byte buffer with valid and ready on both sides
`timescale 1ns/1ps
module mmbi_fifo
  import mmbi_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  mmbi_q_if.fifo q
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array
  logic [AW-1:0] wp_r; // Write index
  logic [AW-1:0] rp_r; // Read index
  logic [CW-1:0] cnt_r; // Fill level
  logic do_push;
  logic do_pop;

  assign q.push_ready = (cnt_r != CW'(DEPTH));
  assign q.pop_valid = (cnt_r != '0);
  assign q.pop_data = mem[rp_r];
  assign q.count = cnt_r;
  assign do_push = q.push_valid && q.push_ready && !q.flush;
  assign do_pop = q.pop_valid && q.pop_ready && !q.flush;

  // Storage write; no reset needed for data
  always_ff @(posedge i_clock)
  begin
    if (do_push)
      mem[wp_r] <= q.push_data;
  end

  // Pointers and level; oldest byte leaves first
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n || q.flush)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      if (do_pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

/* core/mmbi_sync.sv */
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module mmbi_sync
  import mmbi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_level
);
  logic [2:0] sh_r; // sh_r[0] is read only by sh_r[1]

  // Shift chain
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      sh_r <= SYNC_RST;
    else
      sh_r <= {sh_r[1:0], i_pin};
  end

  // Level changes only once stages two and three agree
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      o_level <= 1'b0;
    else if (sh_r[1] == sh_r[2])
      o_level <= sh_r[2];
  end
endmodule

/* core/mmbi_bus_ctrl.sv */
// Minimum-mode bus control, hold handshake and prefetch queue
`timescale 1ns/1ps
module mmbi_bus_ctrl
  import mmbi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_hold,
  input wire logic i_ready,
  input wire logic [15:0] i_ad,
  input wire logic i_eu_req,
  input wire logic i_eu_write,
  input wire logic i_eu_io,
  input wire logic i_eu_int_ack_strobe_n,
  input wire logic [15:0] i_eu_seg,
  input wire logic [15:0] i_eu_off,
  input wire logic [15:0] i_eu_wdata,
  input wire logic i_flush,
  input wire logic [15:0] i_code_seg,
  input wire logic [15:0] i_flush_ip,
  input wire logic i_q_pop,
  input wire logic i_q_first,
  output logic [19:0] o_ad,
  output logic o_ad_oe,
  output logic o_ale,
  output logic o_mio,
  output logic o_mio_oe,
  output logic o_wr_n,
  output logic o_wr_oe,
  output logic o_int_ack_strobe_n,
  output logic o_xcvr_direction,
  output logic o_xcvr_dir_oe,
  output logic o_xcvr_enable_n,
  output logic o_xcvr_en_oe,
  output logic o_bus_grant_out,
  output logic [1:0] o_queue_status,
  output logic o_eu_ack,
  output logic [15:0] o_eu_rdata,
  output logic o_q_valid,
  output logic [7:0] o_q_byte
);
  mmbi_state_t state_r; // Bus state
  mmbi_state_t state_nxt;
  logic hold_s; // Filtered hold request
  logic ready_s; // Filtered ready
  logic cur_fetch_r; // Cycle is a prefetch
  logic cur_write_r; // Cycle writes
  logic cur_io_r; // Cycle targets I/O
  logic cur_int_ack_strobe_n_r; // Cycle acknowledges interrupt
  logic cur_odd_r; // Fetch started on odd byte
  logic [19:0] cur_addr_r; // Physical address
  logic [15:0] cur_wdata_r; // Write data
  logic chain_r; // Next cycle already chosen
  logic drive_r; // Control lines driven
  logic eu_busy_r; // Operand cycle owned
  logic drop_r; // Flushed fetch in flight
  logic [15:0] ip_r; // Prefetch pointer
  logic [15:0] pend_r; // Fetched word awaiting push
  logic [1:0] pend_cnt_r; // Bytes left in pend_r
  logic eu_take; // Operand request usable
  logic fetch_ok; // Room for a word
  logic go; // Start a cycle at this decision
  logic at_dec; // Decision point
  logic cap; // Data captured this edge
  logic inflight; // Fetch not yet captured
  logic [4:0] q_total; // Bytes held or coming
  logic in_t2w; // Next state is T2, T3 or wait
  logic in_t3w4; // Next state is T3, wait or T4
  mmbi_q_if #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) qif ();

  // Requester keeps hold clock aligned; we still filter it
  mmbi_sync u_hold_sync
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_hold),
    .o_level(hold_s)
  );

  // Ready from the addressed device
  mmbi_sync u_ready_sync
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_ready),
    .o_level(ready_s)
  );

  // Byte buffer behind the output stage
  mmbi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .q(qif.fifo)
  );

  // Count bytes held or on their way, except a fetch chained out of T4; keeps six as a ceiling
  assign inflight = cur_fetch_r && !drop_r && !state_r[0] &&
                    !state_r[5] && !state_r[6];
  assign q_total = 5'(qif.count) + 5'(o_q_valid) + 5'(pend_cnt_r) +
                   (inflight ? 5'h2 : 5'h0);
  assign fetch_ok = !i_flush &&
    (q_total + 5'(FETCH_FREE) <= 5'(QUEUE_BYTES));
  assign eu_take = i_eu_req && !eu_busy_r && !o_eu_ack;
  assign go = (eu_take || fetch_ok) && !hold_s;
  assign at_dec = (state_r == MMBI_TI) ||
    ((state_r == MMBI_T3 || state_r == MMBI_TW) && ready_s);
  assign cap = (state_r == MMBI_T3 || state_r == MMBI_TW) && ready_s;

  // Buffer hookup; low byte of a word goes in first
  assign qif.push_valid = (pend_cnt_r != 2'h0);
  assign qif.push_data = (pend_cnt_r == 2'h2) ? pend_r[7:0] : pend_r[15:8];
  assign qif.pop_ready = !o_q_valid || i_q_pop;
  assign qif.flush = i_flush;

  // Next bus state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      MMBI_TI:
        if (hold_s)
          state_nxt = MMBI_HOLD;
        else if (go)
          state_nxt = MMBI_T1;
      MMBI_T1: state_nxt = MMBI_T2;
      MMBI_T2: state_nxt = MMBI_T3;
      MMBI_T3: state_nxt = ready_s ? MMBI_T4 : MMBI_TW;
      MMBI_TW: state_nxt = ready_s ? MMBI_T4 : MMBI_TW;
      MMBI_T4:
        // Grant only at the boundary, never inside a transfer
        if (chain_r)
          state_nxt = MMBI_T1;
        else if (hold_s)
          state_nxt = MMBI_HOLD;
        else
          state_nxt = MMBI_TI;
      MMBI_HOLD:
        if (!hold_s)
          state_nxt = MMBI_TI;
      default: state_nxt = MMBI_TI;
    endcase
  end

  assign in_t2w = state_nxt == MMBI_T2 || state_nxt == MMBI_T3 ||
                  state_nxt == MMBI_TW;
  assign in_t3w4 = state_nxt == MMBI_T3 || state_nxt == MMBI_TW ||
                   state_nxt == MMBI_T4;

  // State register
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      state_r <= MMBI_TI;
    else
      state_r <= state_nxt;
  end

  // Choose the next cycle; operand work beats prefetch
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      cur_fetch_r <= 1'b0;
      cur_write_r <= 1'b0;
      cur_io_r <= 1'b0;
      cur_int_ack_strobe_n_r <= 1'b0;
      cur_odd_r <= 1'b0;
      cur_addr_r <= '0;
      cur_wdata_r <= '0;
      chain_r <= 1'b0;
      ip_r <= RST_IP;
    end
    else
    begin
      if (state_r == MMBI_T4)
        chain_r <= 1'b0;
      if (at_dec && go)
      begin
        chain_r <= (state_r != MMBI_TI);
        cur_fetch_r <= !eu_take;
        cur_write_r <= eu_take && i_eu_write;
        cur_io_r <= eu_take && i_eu_io;
        cur_int_ack_strobe_n_r <= eu_take && i_eu_int_ack_strobe_n;
        cur_odd_r <= !eu_take && ip_r[0];
        cur_wdata_r <= i_eu_wdata;
        if (eu_take)
          cur_addr_r <= mmbi_reloc(i_eu_seg, i_eu_off);
        else
        begin
          cur_addr_r <= mmbi_reloc(i_code_seg, {ip_r[15:1], 1'b0});
          ip_r <= {ip_r[15:1] + 15'h1, 1'b0};
        end
      end
      if (i_flush)
        ip_r <= i_flush_ip;
    end
  end

  // Select and direction settle at the decision, before T1 or in T4
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_mio <= 1'b1;
      o_xcvr_direction <= 1'b0;
    end
    else if (at_dec && go)
    begin
      o_mio <= !(eu_take && (i_eu_io || i_eu_int_ack_strobe_n));
      o_xcvr_direction <= eu_take && i_eu_write;
    end
  end

  // Control line drive; off in the same clock the grant rises
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      drive_r <= 1'b1;
    else if (state_nxt == MMBI_HOLD)
      drive_r <= 1'b0;
    else if (at_dec && go)
      drive_r <= 1'b1;
  end
  assign o_mio_oe = drive_r;
  assign o_wr_oe = drive_r;
  assign o_xcvr_dir_oe = drive_r;
  assign o_xcvr_en_oe = drive_r;

  // Strobes and latch pulse, all from the next state
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_ale <= 1'b0;
      o_wr_n <= 1'b1;
      o_int_ack_strobe_n <= 1'b1;
      o_xcvr_enable_n <= 1'b1;
      o_bus_grant_out <= 1'b0;
    end
    else
    begin
      o_ale <= (state_nxt == MMBI_T1);
      o_wr_n <= !(cur_write_r && in_t2w);
      o_int_ack_strobe_n <= !(cur_int_ack_strobe_n_r && in_t2w);
      // Reads open a clock late: nearest edge to mid T2
      if (cur_write_r)
        o_xcvr_enable_n <= !(in_t3w4 || state_nxt == MMBI_T2);
      else
        o_xcvr_enable_n <= !(in_t3w4 && !cur_fetch_r ||
                             in_t3w4 && cur_fetch_r);
      o_bus_grant_out <= (state_nxt == MMBI_HOLD);
    end
  end

  // Multiplexed bus: address in T1, write data T2 to T4
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_ad <= '0;
      o_ad_oe <= 1'b0;
    end
    else
    begin
      if (state_nxt == MMBI_T1)
        o_ad <= (at_dec && go && !eu_take) ?
                mmbi_reloc(i_code_seg, {ip_r[15:1], 1'b0}) :
                (at_dec && go) ? mmbi_reloc(i_eu_seg, i_eu_off) : cur_addr_r;
      else if (state_nxt == MMBI_T2)
        o_ad <= {cur_addr_r[19:16], cur_wdata_r};
      o_ad_oe <= (state_nxt == MMBI_T1) ||
                 (cur_write_r && (in_t2w || state_nxt == MMBI_T4));
    end
  end

  // Operand handshake and read capture at entry to T4
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      o_eu_ack <= 1'b0;
      o_eu_rdata <= '0;
      eu_busy_r <= 1'b0;
    end
    else
    begin
      o_eu_ack <= cap && !cur_fetch_r;
      if (cap && !cur_fetch_r)
        o_eu_rdata <= i_ad;
      if (at_dec && go && eu_take)
        eu_busy_r <= 1'b1;
      else if (o_eu_ack)
        eu_busy_r <= 1'b0;
    end
  end

  // Fetched word into the pending pair; a flush discards it
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      pend_r <= '0;
      pend_cnt_r <= 2'h0;
      drop_r <= 1'b0;
    end
    else if (i_flush)
    begin
      pend_cnt_r <= 2'h0;
      // A fetch chained out of T4 is also on its way; one landing now
      // is already gone, so it must not poison the next fetch
      drop_r <= (inflight && !cap) ||
                (state_r == MMBI_T4 && chain_r && cur_fetch_r);
    end
    else
    begin
      if (cap && cur_fetch_r)
        drop_r <= 1'b0;
      if (cap && cur_fetch_r && !drop_r)
      begin
        pend_r <= i_ad;
        pend_cnt_r <= cur_odd_r ? 2'h1 : 2'h2;
      end
      else if (qif.push_valid && qif.push_ready)
        pend_cnt_r <= pend_cnt_r - 2'h1;
    end
  end

  // Output stage refills from the buffer as soon as it is empty
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n || i_flush)
    begin
      o_q_valid <= 1'b0;
      o_q_byte <= '0;
    end
    else if (qif.pop_ready)
    begin
      o_q_valid <= qif.pop_valid;
      if (qif.pop_valid)
        o_q_byte <= qif.pop_data;
    end
  end

  // Queue status one clock after the operation
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
      o_queue_status <= QS_NOP;
    else if (i_flush)
      o_queue_status <= QS_EMPTY;
    else if (i_q_pop && o_q_valid)
      o_queue_status <= i_q_first ? QS_FIRST : QS_NEXT;
    else
      o_queue_status <= QS_NOP;
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_ale_single: assert property (o_ale |=> !o_ale [*3])
    else $error("latch pulse repeated inside a cycle");
  a_hold_float: assert property (o_bus_grant_out |->
    !o_mio_oe && !o_wr_oe && !o_xcvr_en_oe && !o_ad_oe)
    else $error("lines driven during grant");
  a_grant_boundary: assert property ($rose(o_bus_grant_out) |->
    $past(state_r == MMBI_TI || state_r == MMBI_T4))
    else $error("grant outside a boundary");
  a_grant_drop: assert property (o_bus_grant_out && !hold_s |=>
    !o_bus_grant_out ##0 !o_mio_oe)
    else $error("grant held after request fell");
  a_write_strobe: assert property (!o_wr_n |-> cur_write_r &&
    (state_r == MMBI_T2 || state_r == MMBI_T3 || state_r == MMBI_TW))
    else $error("write strobe outside T2 to wait");
  a_int_ack_strobe_n_strobe: assert property ($fell(o_int_ack_strobe_n) |->
    state_r == MMBI_T2 && cur_int_ack_strobe_n_r)
    else $error("acknowledge strobe misplaced");
  a_den_read: assert property ($fell(o_xcvr_enable_n) &&
    !cur_write_r |-> state_r == MMBI_T3)
    else $error("read enable not at T3");
  a_den_write: assert property ($fell(o_xcvr_enable_n) &&
    cur_write_r |-> state_r == MMBI_T2)
    else $error("write enable not at T2");
  a_queue_cap: assert property (q_total <= 5'(QUEUE_BYTES))
    else $error("queue over six bytes");
  a_fetch_start: assert property (state_r == MMBI_TI &&
    !hold_s && fetch_ok |=> state_r == MMBI_T1 ##0 o_ale)
    else $error("fetch not started with room");
  a_select_stable: assert property (state_r == MMBI_T1 |=>
    $stable(o_mio) && $stable(o_xcvr_direction) [*2])
    else $error("select changed mid cycle");
  a_status_pop: assert property (i_q_pop && o_q_valid &&
    !i_flush |=> o_queue_status[0])
    else $error("pop not reported");

  c_hold: cover property ($rose(o_bus_grant_out));
  c_wait: cover property (state_r == MMBI_TW ##1 state_r == MMBI_T4);
  c_write: cover property ($fell(o_wr_n));
  c_flush: cover property (i_flush && inflight);
endmodule

/* dv/mmbi_mem_model.sv */
// Memory and I/O partner that answers bus cycles of the bus control block
`timescale 1ns/1ps
module mmbi_mem_model
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input wire logic i_ale,
  input wire logic [19:0] i_ad,
  input wire logic i_wr_n,
  input wire logic i_xcvr_direction,
  input wire logic i_xcvr_enable_n,
  output logic [15:0] o_rdata,
  output logic o_ready,
  output logic [15:0] o_wdata
);
  logic [19:0] addr_r; // Latched address of the cycle
  logic [7:0] since_r; // Clocks since the address pulse
  logic [15:0] last_r; // Last value on the data lines
  logic [19:0] even_w; // Even word address

  // Byte contents derive from the address, so no storage is needed
  function automatic logic [7:0] mem_byte(input logic [19:0] a);
    mem_byte = a[7:0] ^ 8'ha5;
  endfunction

  // Address capture, wait counter and write capture
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_n)
    begin
      addr_r <= 20'h00000;
      since_r <= 8'h00;
      o_wdata <= 16'h0000;
      last_r <= 16'h0000;
    end
    else
    begin
      if (i_ale)
      begin
        addr_r <= i_ad;
        since_r <= 8'h00;
      end
      else if (since_r != 8'hff)
        since_r <= since_r + 8'h01;
      // Write data stands while the strobe is low
      if (!i_wr_n)
        o_wdata <= i_ad[15:0];
      last_r <= o_rdata;
    end
  end

  assign even_w = {addr_r[19:1], 1'b0};
  // Data lines show the word only while receiving; otherwise they
  // toggle so a stale value cannot pass for a real answer
  assign o_rdata = (!i_xcvr_enable_n && !i_xcvr_direction) ?
                   {mem_byte(even_w | 20'h00001), mem_byte(even_w)} :
                   ~last_r;
  // Slow device: not ready except a short window, forcing waits
  assign o_ready = !i_slow ||
                   (since_r >= 8'h08 && since_r < 8'h0c);
endmodule

/* dv/mmbi_bus_ctrl_test.sv */
// Self-checking testbench of the minimum-mode bus control block
`timescale 1ns/1ps
module mmbi_bus_ctrl_test
  import mmbi_pkg::*;
;
  logic i_clock, i_rst_n, i_hold, i_ready, i_slow;
  logic i_eu_req, i_eu_write, i_eu_io, i_eu_int_ack_strobe_n, i_flush;
  logic i_q_pop, i_q_first;
  logic [15:0] i_ad, i_eu_seg, i_eu_off, i_eu_wdata, i_code_seg, i_flush_ip;
  logic [19:0] o_ad;
  logic o_ad_oe, o_ale, o_mio, o_mio_oe, o_wr_n, o_wr_oe;
  logic o_int_ack_strobe_n, o_xcvr_direction, o_xcvr_dir_oe;
  logic o_xcvr_enable_n, o_xcvr_en_oe, o_bus_grant_out;
  logic [1:0] o_queue_status;
  logic o_eu_ack, o_q_valid;
  logic [15:0] o_eu_rdata, mem_wdata;
  logic [7:0] o_q_byte;
  int n_fail, n_tests, cyc, c; // Counters
  int t_ale, t_ack, nwr, nint; // Results of one operand cycle
  logic [19:0] a_seen;
  logic mio_seen, dir_seen, en_t2;
  logic [15:0] rd_seen;

  mmbi_bus_ctrl dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_hold(i_hold), .i_ready(i_ready), .i_ad(i_ad),
    .i_eu_req(i_eu_req), .i_eu_write(i_eu_write), .i_eu_io(i_eu_io),
    .i_eu_int_ack_strobe_n(i_eu_int_ack_strobe_n), .i_eu_seg(i_eu_seg), .i_eu_off(i_eu_off),
    .i_eu_wdata(i_eu_wdata), .i_flush(i_flush), .i_code_seg(i_code_seg),
    .i_flush_ip(i_flush_ip), .i_q_pop(i_q_pop), .i_q_first(i_q_first),
    .o_ad(o_ad), .o_ad_oe(o_ad_oe), .o_ale(o_ale), .o_mio(o_mio),
    .o_mio_oe(o_mio_oe), .o_wr_n(o_wr_n), .o_wr_oe(o_wr_oe),
    .o_int_ack_strobe_n(o_int_ack_strobe_n),
    .o_xcvr_direction(o_xcvr_direction), .o_xcvr_dir_oe(o_xcvr_dir_oe),
    .o_xcvr_enable_n(o_xcvr_enable_n), .o_xcvr_en_oe(o_xcvr_en_oe),
    .o_bus_grant_out(o_bus_grant_out), .o_queue_status(o_queue_status),
    .o_eu_ack(o_eu_ack), .o_eu_rdata(o_eu_rdata), .o_q_valid(o_q_valid),
    .o_q_byte(o_q_byte));

  mmbi_mem_model mem_u (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_slow(i_slow), .i_ale(o_ale), .i_ad(o_ad), .i_wr_n(o_wr_n),
    .i_xcvr_direction(o_xcvr_direction),
    .i_xcvr_enable_n(o_xcvr_enable_n), .o_rdata(i_ad),
    .o_ready(i_ready), .o_wdata(mem_wdata));

  // Free-running 40 MHz clock
  always #12.5 i_clock = ~i_clock;

  // Own copy of the memory contents for expectations
  function automatic logic [7:0] eb(input logic [19:0] a);
    eb = a[7:0] ^ 8'ha5;
  endfunction

  task automatic check(input string what, input logic [19:0] seen,
                       input logic [19:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard: the whole run needs well under this many clocks
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic count_ale(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge i_clock);
      if (o_ale === 1'b1)
        k++;
    end
  endtask

  // Take the head byte and judge byte and status
  task automatic pop_one(input logic first, input logic [7:0] exp);
    int k;
    k = 0;
    @(negedge i_clock);
    while (o_q_valid !== 1'b1 && k < 50)
    begin
      @(negedge i_clock);
      k++;
    end
    check("head valid", 20'(o_q_valid), 20'h00001);
    check("head byte", {12'h000, o_q_byte}, {12'h000, exp});
    @(posedge i_clock);
    i_q_pop <= 1'b1;
    i_q_first <= first;
    @(posedge i_clock);
    i_q_pop <= 1'b0;
    i_q_first <= 1'b0;
    @(negedge i_clock);
    check("queue status", {18'h0, o_queue_status},
          {18'h0, first ? QS_FIRST : QS_NEXT});
  endtask

  // Run one operand cycle and record what the bus showed
  task automatic op(input logic wr, io, ia,
                    input logic [15:0] seg, off, wd);
    int t;
    t = 0;
    t_ale = 0;
    t_ack = 0;
    nwr = 0;
    nint = 0;
    @(posedge i_clock);
    i_eu_req <= 1'b1;
    i_eu_write <= wr;
    i_eu_io <= io;
    i_eu_int_ack_strobe_n <= ia;
    i_eu_seg <= seg;
    i_eu_off <= off;
    i_eu_wdata <= wd;
    while (t_ack == 0 && t < 80)
    begin
      @(negedge i_clock);
      t++;
      if (o_ale === 1'b1)
      begin
        t_ale = t;
        a_seen = o_ad;
        mio_seen = o_mio;
        dir_seen = o_xcvr_direction;
      end
      if (t_ale != 0 && t == t_ale + 1)
        en_t2 = o_xcvr_enable_n;
      if (o_wr_n === 1'b0)
        nwr++;
      if (o_int_ack_strobe_n === 1'b0)
        nint++;
      if (o_eu_ack === 1'b1)
      begin
        t_ack = t;
        rd_seen = o_eu_rdata;
      end
    end
    @(posedge i_clock);
    i_eu_req <= 1'b0;
    check("operand ack", 20'(t_ack != 0), 20'h00001);
  endtask

  // Fill after reset, then refetch only with two slots free
  task automatic t_queue;
    count_ale(80, c);
    check("fills to capacity", 20'(c), 20'h00003);
    pop_one(1'b1, eb(20'h00100));
    count_ale(20, c);
    check("one slot free", 20'(c), 20'h00000);
    pop_one(1'b0, eb(20'h00101));
    count_ale(20, c);
    check("two slots free", 20'(c), 20'h00001);
  endtask

  // Flush to an odd pointer; the byte at the odd address must come out first
  task automatic t_flush;
    @(posedge i_clock);
    i_flush <= 1'b1;
    i_flush_ip <= 16'h0007;
    @(posedge i_clock);
    i_flush <= 1'b0;
    @(negedge i_clock);
    check("flush status", {18'h0, o_queue_status},
          {18'h0, QS_EMPTY});
    pop_one(1'b1, eb(20'h00107));
    pop_one(1'b0, eb(20'h00108));
    count_ale(60, c);
  endtask

  // Read, I/O write, acknowledge and a slow write
  task automatic t_ops;
    op(1'b0, 1'b0, 1'b0, 16'h1234, 16'h0010, 16'h0000);
    check("read address", a_seen, 20'h12350);
    check("read select", 20'(mio_seen), 20'h00001);
    check("read direction", 20'(dir_seen), 20'h00000);
    check("read enable T2", 20'(en_t2), 20'h00001);
    check("read data", 20'(rd_seen),
          {4'h0, eb(20'h12351), eb(20'h12350)});
    op(1'b1, 1'b1, 1'b0, 16'h0000, 16'h0040, 16'hbeef);
    check("write select", 20'(mio_seen), 20'h00000);
    check("write direction", 20'(dir_seen), 20'h00001);
    check("write enable T2", 20'(en_t2), 20'h00000);
    check("write strobe", 20'(nwr), 20'(t_ack - t_ale - 1));
    check("write data", 20'(mem_wdata), 20'h0beef);
    op(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
    check("ack strobe", 20'(nint), 20'(t_ack - t_ale - 1));
    check("ack no write", 20'(nwr), 20'h00000);
    check("ack enable T2", 20'(en_t2), 20'h00001);
    i_slow <= 1'b1;
    op(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0080, 16'h1357);
    i_slow <= 1'b0;
    check("waits inserted", 20'(t_ack - t_ale > 3), 20'h00001);
    check("strobe in waits", 20'(nwr), 20'(t_ack - t_ale - 1));
  endtask

  // Grant the bus, float it, then take it back for a fetch
  task automatic t_hold;
    int k;
    k = 0;
    @(posedge i_clock);
    i_hold <= 1'b1;
    while (o_bus_grant_out !== 1'b1 && k < 40)
    begin
      @(negedge i_clock);
      k++;
    end
    check("grant", 20'(o_bus_grant_out), 20'h00001);
    check("floated", {15'h0, o_ad_oe, o_mio_oe, o_wr_oe, o_xcvr_dir_oe,
          o_xcvr_en_oe}, 20'h00000);
    pop_one(1'b1, eb(20'h00109));
    pop_one(1'b0, eb(20'h0010a));
    count_ale(10, c);
    check("no cycle in hold", 20'(c), 20'h00000);
    @(posedge i_clock);
    i_hold <= 1'b0;
    k = 0;
    while (o_bus_grant_out !== 1'b0 && k < 20)
    begin
      @(negedge i_clock);
      k++;
    end
    check("grant dropped", 20'(o_bus_grant_out), 20'h00000);
    count_ale(30, c);
    check("bus retaken", 20'(c), 20'h00001);
    check("select driven", 20'(o_mio_oe), 20'h00001);
  endtask

  // Main sequence
  initial
  begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    i_hold = 1'b0;
    i_slow = 1'b0;
    i_eu_req = 1'b0;
    i_eu_write = 1'b0;
    i_eu_io = 1'b0;
    i_eu_int_ack_strobe_n = 1'b0;
    i_eu_seg = 16'h0000;
    i_eu_off = 16'h0000;
    i_eu_wdata = 16'h0000;
    i_flush = 1'b0;
    i_code_seg = 16'h0010;
    i_flush_ip = 16'h0000;
    i_q_pop = 1'b0;
    i_q_first = 1'b0;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_queue();
    t_flush();
    t_ops();
    t_hold();
    stop_test();
  end
endmodule
